// ---- gpe_pkg.sv ----
// Purpose: Shared constants for the general-purpose pin port with edge interrupts.
// Assumes: Registers are 16-bit words at word addresses on the internal I/O bus.
// Notes:   Each pair of registers covers pins 15..0 (low) and 31..16 (high).
package gpe_pkg;

    // Register word addresses.
    localparam logic [15:0] ADDR_DIR_LO   = 16'h1c06;
    localparam logic [15:0] ADDR_DIR_HI   = 16'h1c07;
    localparam logic [15:0] ADDR_IN_LO    = 16'h1c08;
    localparam logic [15:0] ADDR_IN_HI    = 16'h1c09;
    localparam logic [15:0] ADDR_OUT_LO   = 16'h1c0a;
    localparam logic [15:0] ADDR_OUT_HI   = 16'h1c0b;
    localparam logic [15:0] ADDR_EDGE_LO  = 16'h1c0c;
    localparam logic [15:0] ADDR_EDGE_HI  = 16'h1c0d;
    localparam logic [15:0] ADDR_IEN_LO   = 16'h1c0e;
    localparam logic [15:0] ADDR_IEN_HI   = 16'h1c0f;
    localparam logic [15:0] ADDR_FLAG_LO  = 16'h1c10;
    localparam logic [15:0] ADDR_FLAG_HI  = 16'h1c11;

    // Reset values of the writable registers and of the pull-down enables.
    localparam logic [31:0] RST_DIR       = 32'h0000_0000;
    localparam logic [31:0] RST_OUT       = 32'h0000_0000;
    localparam logic [31:0] RST_EDGE      = 32'h0000_0000;
    localparam logic [31:0] RST_IEN       = 32'h0000_0000;
    localparam logic [31:0] RST_FLAG      = 32'h0000_0000;
    localparam logic [31:0] RST_PD        = 32'hffff_ffff;

    // Timing counts in system clock cycles.
    localparam logic [1:0]  OUT_HOLD_CYC  = 2'h3;
    localparam int          DIN_LAT_CYC   = 5;
    localparam int          FLAG_LAT_CYC  = 7;
    localparam int          IRQ_LAT_CYC   = 8;
    localparam int          PIPE_DEPTH    = FLAG_LAT_CYC;

    // Field positions: bit 0 of a low register is pin 0, of a high one pin 16.
    localparam int          HALF_W        = 16;
    localparam int          PIN_CNT       = 32;

endpackage

// ---- gpe_port.sv ----
// Purpose: Pin port with per-pin direction, output data, edge-select interrupts.
// Assumes: One 200 MHz system clock; pins are asynchronous to it.
// Notes:   Direction bit 1 means output; edge-select bit 1 means rising edge.
`timescale 1ns/1ps

module gpe_port (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_wdata,
    input  wire logic [31:0] i_pin_in,
    input  wire logic [31:0] i_pulldown_dis,
    output logic      [15:0] o_rdata,
    output logic             o_rvalid,
    output logic      [31:0] o_pin_out,
    output logic      [31:0] o_pin_oe,
    output logic      [31:0] o_pulldown_en,
    output logic             o_irq
);

    typedef struct packed {
        logic [31:0]       dir;
        logic [31:0]       dout;
        logic [31:0]       edge_sel;
        logic [31:0]       irq_en;
        logic [31:0]       flag;
        logic [31:0]       pin_out;
        logic [6:0][31:0]  pipe;
        logic [31:0][1:0]  hold;
        logic [31:0]       pd_en;
        logic              irq;
        logic [15:0]       rdata;
        logic              rvalid;
    } gpe_state_type;

    gpe_state_type st_r;
    gpe_state_type st_nxt;
    logic [31:0]   rise;
    logic [31:0]   fall;
    logic [31:0]   hit;
    logic [31:0]   clr;

    // Edge detection looks at the two oldest pipeline stages only.
    assign rise = st_r.pipe[5] & ~st_r.pipe[6];
    assign fall = ~st_r.pipe[5] & st_r.pipe[6];
    assign hit  = (st_r.edge_sel & rise) | (~st_r.edge_sel & fall);

    // Next-state logic for registers, pin pipeline, outputs and read data.
    always_comb begin
        st_nxt = st_r;
        clr    = 32'h0000_0000;
        // Stages 0 and 1 synchronise; the rest add latency toward the flags.
        st_nxt.pipe = {st_r.pipe[5:0], i_pin_in};
        if (i_wr) begin
            unique case (i_addr)
                gpe_pkg::ADDR_DIR_LO:  st_nxt.dir[15:0]       = i_wdata;
                gpe_pkg::ADDR_DIR_HI:  st_nxt.dir[31:16]      = i_wdata;
                gpe_pkg::ADDR_OUT_LO:  st_nxt.dout[15:0]      = i_wdata;
                gpe_pkg::ADDR_OUT_HI:  st_nxt.dout[31:16]     = i_wdata;
                gpe_pkg::ADDR_EDGE_LO: st_nxt.edge_sel[15:0]  = i_wdata;
                gpe_pkg::ADDR_EDGE_HI: st_nxt.edge_sel[31:16] = i_wdata;
                gpe_pkg::ADDR_IEN_LO:  st_nxt.irq_en[15:0]    = i_wdata;
                gpe_pkg::ADDR_IEN_HI:  st_nxt.irq_en[31:16]   = i_wdata;
                gpe_pkg::ADDR_FLAG_LO: clr[15:0]              = i_wdata;
                gpe_pkg::ADDR_FLAG_HI: clr[31:16]             = i_wdata;
                default: ;
            endcase
        end
        // A detected edge outranks a clear in the same cycle.
        st_nxt.flag = (st_r.flag & ~clr) | hit;
        // Interrupt follows the flags one cycle later, gated per pin.
        st_nxt.irq = |(st_r.flag & st_r.irq_en);
        st_nxt.pd_en = ~i_pulldown_dis;
        // Each pin output may only toggle after it has stood three cycles.
        for (int i = 0; i < gpe_pkg::PIN_CNT; i++) begin
            if (st_r.hold[i] != 2'h0) begin
                st_nxt.hold[i] = st_r.hold[i] - 2'h1;
            end else if (st_r.dout[i] != st_r.pin_out[i]) begin
                st_nxt.pin_out[i] = st_r.dout[i];
                st_nxt.hold[i]    = gpe_pkg::OUT_HOLD_CYC - 2'h1;
            end
        end
        // Read data is registered; unmapped addresses read as zero.
        st_nxt.rvalid = i_rd;
        st_nxt.rdata  = 16'h0000;
        if (i_rd) begin
            unique case (i_addr)
                gpe_pkg::ADDR_DIR_LO:  st_nxt.rdata = st_r.dir[15:0];
                gpe_pkg::ADDR_DIR_HI:  st_nxt.rdata = st_r.dir[31:16];
                gpe_pkg::ADDR_IN_LO:   st_nxt.rdata = st_r.pipe[4][15:0];
                gpe_pkg::ADDR_IN_HI:   st_nxt.rdata = st_r.pipe[4][31:16];
                gpe_pkg::ADDR_OUT_LO:  st_nxt.rdata = st_r.dout[15:0];
                gpe_pkg::ADDR_OUT_HI:  st_nxt.rdata = st_r.dout[31:16];
                gpe_pkg::ADDR_EDGE_LO: st_nxt.rdata = st_r.edge_sel[15:0];
                gpe_pkg::ADDR_EDGE_HI: st_nxt.rdata = st_r.edge_sel[31:16];
                gpe_pkg::ADDR_IEN_LO:  st_nxt.rdata = st_r.irq_en[15:0];
                gpe_pkg::ADDR_IEN_HI:  st_nxt.rdata = st_r.irq_en[31:16];
                gpe_pkg::ADDR_FLAG_LO: st_nxt.rdata = st_r.flag[15:0];
                gpe_pkg::ADDR_FLAG_HI: st_nxt.rdata = st_r.flag[31:16];
                default:               st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // State register; every field resets to a constant.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r          <= '0;
            st_r.dir      <= gpe_pkg::RST_DIR;
            st_r.dout     <= gpe_pkg::RST_OUT;
            st_r.edge_sel <= gpe_pkg::RST_EDGE;
            st_r.irq_en   <= gpe_pkg::RST_IEN;
            st_r.flag     <= gpe_pkg::RST_FLAG;
            st_r.pin_out  <= gpe_pkg::RST_OUT;
            st_r.pd_en    <= gpe_pkg::RST_PD;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign o_rdata       = st_r.rdata;
    assign o_rvalid      = st_r.rvalid;
    assign o_pin_out     = st_r.pin_out;
    assign o_pin_oe      = st_r.dir;
    assign o_pulldown_en = st_r.pd_en;
    assign o_irq         = st_r.irq;

    // Helper counter so latency checks only start once the pipeline is full.
    logic [3:0] warm_r;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            warm_r <= 4'h0;
        end else if (warm_r != 4'hf) begin
            warm_r <= warm_r + 4'h1;
        end
    end

    // Checks of the port behaviour.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    a_din_latency: assert property (
        (warm_r > 4'h6) |-> (st_r.pipe[4] == $past(i_pin_in, 5)))
        else $error("Input data register does not show pins after five cycles.");
    a_flag_rise: assert property (
        (st_r.edge_sel[0] && st_r.pipe[5][0] && !st_r.pipe[6][0]) |=> st_r.flag[0])
        else $error("Rising edge on pin 0 did not set its flag.");
    a_flag_fall: assert property (
        (!st_r.edge_sel[1] && !st_r.pipe[5][1] && st_r.pipe[6][1]) |=> st_r.flag[1])
        else $error("Falling edge on pin 1 did not set its flag.");
    a_irq_gate: assert property (
        ##1 (o_irq == $past(|(st_r.flag & st_r.irq_en))))
        else $error("Interrupt output does not follow enabled flags.");
    a_out_hold_high: assert property (
        $rose(o_pin_out[0]) |-> o_pin_out[0] [*3])
        else $error("Pin 0 high for fewer than three cycles.");
    a_out_hold_low: assert property (
        $fell(o_pin_out[2]) |-> !o_pin_out[2] [*3])
        else $error("Pin 2 low for fewer than three cycles.");
    a_w1c_clear: assert property (
        (i_wr && i_addr == gpe_pkg::ADDR_FLAG_LO && i_wdata[3] && !hit[3]) |=> !st_r.flag[3])
        else $error("Write of one did not clear flag 3.");
    a_set_wins: assert property (
        (i_wr && i_addr == gpe_pkg::ADDR_FLAG_HI && i_wdata[0] && hit[16]) |=> st_r.flag[16])
        else $error("Clear overrode a new edge on pin 16.");
    a_oe_dir: assert property (
        (i_wr && i_addr == gpe_pkg::ADDR_DIR_LO) |=> (o_pin_oe[15:0] == $past(i_wdata)))
        else $error("Direction write did not reach output enables.");
    a_read_answer: assert property (
        i_rd |=> o_rvalid)
        else $error("Read was not answered in the next cycle.");

    c_irq_raised:  cover property ($rose(o_irq));
    c_set_and_clr: cover property (i_wr && i_addr == gpe_pkg::ADDR_FLAG_LO && (|hit[15:0]));
    c_out_toggle:  cover property ($rose(o_pin_out[0]) ##3 $fell(o_pin_out[0]));

endmodule

// ---- gpe_pin_model.sv ----
// Purpose: Model of the external logic that drives the port's input pins.
// Assumes: Pins change only at the falling clock edge, away from sampling.
// Notes:   Every level is held at least two clocks before the next change.
`timescale 1ns/1ps
module gpe_pin_model (
    input  wire logic        i_clk,
    output logic      [31:0] o_pins
);
    int held = 8;
    // Counts rising edges since the last pin change.
    always @(posedge i_clk) held <= held + 1;
    // Waits out the minimum pulse width, then moves one pin off the sampling edge.
    task automatic set_pin(input int idx, input logic lvl);
        while (held < 2) @(posedge i_clk);
        @(negedge i_clk);
        o_pins[idx] = lvl;
        held = 0;
    endtask
    initial o_pins = 32'h0000_0000;
endmodule

// ---- gpe_port_bench.sv ----
// Purpose: Self-checking bench for the pin port with edge interrupts.
// Assumes: Bench drives inputs at the falling edge; design samples on rising.
// Notes:   Reset first, then register rows, then hold and interrupt cases by hand.
`timescale 1ns/1ps
module gpe_port_bench;
    typedef struct {logic [15:0] a; logic [15:0] w; logic [15:0] e;} gpe_row_type;
    logic        i_clk, i_reset_n, i_wr, i_rd, o_rvalid, o_irq;
    logic [15:0] i_addr, i_wdata, o_rdata;
    logic [31:0] i_pin_in, i_pulldown_dis, o_pin_out, o_pin_oe, o_pulldown_en;
    int          error_cnt = 0;
    int          compares = 0;
    int          n, h, l;
    gpe_row_type rows [9] = '{'{gpe_pkg::ADDR_DIR_LO, 16'ha5a5, 16'ha5a5},
        '{gpe_pkg::ADDR_DIR_HI, 16'h5a5a, 16'h5a5a}, '{gpe_pkg::ADDR_OUT_LO, 16'h1234, 16'h1234},
        '{gpe_pkg::ADDR_OUT_HI, 16'h8001, 16'h8001}, '{gpe_pkg::ADDR_EDGE_LO, 16'hffff, 16'hffff},
        '{gpe_pkg::ADDR_IEN_HI, 16'h00ff, 16'h00ff}, '{gpe_pkg::ADDR_IN_LO, 16'hffff, 16'h0000},
        '{gpe_pkg::ADDR_FLAG_HI, 16'h0000, 16'h0000}, '{16'h1c12, 16'hffff, 16'h0000}};
    gpe_port dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wr(i_wr),
        .i_rd(i_rd), .i_wdata(i_wdata), .i_pin_in(i_pin_in), .i_pulldown_dis(i_pulldown_dis),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_pulldown_en(o_pulldown_en), .o_irq(o_irq));
    gpe_pin_model u_pins (.i_clk(i_clk), .o_pins(i_pin_in));
    // Compares one value and counts the comparison.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    // Issues one single-cycle write strobe.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge i_clk);
        i_wr = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_wr = 1'b0;
    endtask
    // Issues one read strobe and checks the answer while it stands for its one cycle.
    task automatic rd(input logic [15:0] a, input logic [15:0] e, input string msg);
        @(negedge i_clk);
        i_rd = 1'b1;
        i_addr = a;
        @(negedge i_clk);
        chk({15'h0000, o_rvalid, o_rdata}, {16'h0001, e}, msg);
        i_rd = 1'b0;
    endtask
    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Free-running 200 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // Cuts a hang short well after the expected run of under a hundred cycles.
    initial begin
        #20000;
        error_cnt++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        i_reset_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 16'h0000;
        i_wdata = 16'h0000;
        i_pulldown_dis = 32'h0000_ffff;
        repeat (2) @(negedge i_clk);
        chk(o_pulldown_en, 32'hffff_ffff, "reset pulldown");
        chk(o_pin_oe | o_pin_out | {31'h0, o_irq}, 32'h0, "reset outputs");
        i_reset_n = 1'b1;
        @(negedge i_clk);
        chk(o_pulldown_en, 32'hffff_0000, "pulldown control");
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].w);
            rd(rows[k].a, rows[k].e, "register row");
        end
        chk(o_pin_oe, 32'h5a5a_a5a5, "direction");
        chk(o_pin_out, 32'h8001_1234, "pin levels");
        // Back-to-back output toggles must still give full-width pulses.
        fork
            begin
                wr(gpe_pkg::ADDR_OUT_LO, 16'h0001);
                wr(gpe_pkg::ADDR_OUT_LO, 16'h0000);
                wr(gpe_pkg::ADDR_OUT_LO, 16'h0001);
            end
            begin
                h = 0;
                l = 0;
                wait (o_pin_out[0] === 1'b1);
                while (o_pin_out[0] === 1'b1 && h < 10) begin
                    @(posedge i_clk);
                    #1;
                    h++;
                end
                while (o_pin_out[0] === 1'b0 && l < 10) begin
                    @(posedge i_clk);
                    #1;
                    l++;
                end
            end
        join
        chk(h, 32'd3, "high width");
        chk(l, 32'd3, "low width");
        // Rising edge on pin 0 with its interrupt enabled.
        wr(gpe_pkg::ADDR_EDGE_LO, 16'h0001);
        wr(gpe_pkg::ADDR_IEN_LO, 16'h0001);
        u_pins.set_pin(0, 1'b1);
        n = 0;
        while (o_irq !== 1'b1 && n < 20) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk(n, gpe_pkg::IRQ_LAT_CYC, "irq latency");
        rd(gpe_pkg::ADDR_FLAG_LO, 16'h0001, "rise flag");
        rd(gpe_pkg::ADDR_IN_LO, 16'h0001, "pin sample");
        wr(gpe_pkg::ADDR_FLAG_LO, 16'h0001);
        rd(gpe_pkg::ADDR_FLAG_LO, 16'h0000, "flag clear");
        chk(o_irq, 32'h0, "irq clear");
        // Falling edge with the enable off: flag only, no interrupt.
        wr(gpe_pkg::ADDR_EDGE_LO, 16'h0000);
        wr(gpe_pkg::ADDR_IEN_LO, 16'h0000);
        u_pins.set_pin(0, 1'b0);
        u_pins.set_pin(16, 1'b1);
        repeat (10) @(posedge i_clk);
        #1;
        chk(o_irq, 32'h0, "masked irq");
        rd(gpe_pkg::ADDR_FLAG_LO, 16'h0001, "fall flag");
        rd(gpe_pkg::ADDR_IN_HI, 16'h0001, "high half");
        report_and_stop();
    end
endmodule
